// file: rtl/rcw_consts.svh
// Offsets, field positions, reset values and frame constants of the
// second receiver configuration word.
// Assumes inclusion by the design modules and the testbench only.
`ifndef RCW_CONSTS_SVH
`define RCW_CONSTS_SVH

// ----------------------------------------------------------------
// Address map
// ----------------------------------------------------------------
`define RCW_ADDR_W          16
`define RCW_ADDR_WORD1      16'h0404

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RCW_BIT_RESET       31
`define RCW_BIT_JUMBO       30
`define RCW_BIT_FCS_PASS    29
`define RCW_BIT_RX_ENABLE   28
`define RCW_BIT_VLAN        27
`define RCW_BIT_PREAMBLE    26
`define RCW_BIT_LT_OFF      25
`define RCW_BIT_CTRL_OFF    24
`define RCW_BIT_ENH_VLAN    23
`define RCW_BIT_STACK_VLAN  21
`define RCW_PAUSE_MSB       15
`define RCW_PAUSE_LSB       0

// ----------------------------------------------------------------
// Reset value and writable bits
// ----------------------------------------------------------------
`define RCW_WORD1_RESET     32'h1000_0000
`define RCW_WORD1_RMASK     32'h7FA0_FFFF

// ----------------------------------------------------------------
// Frame constants
// ----------------------------------------------------------------
`define RCW_LEN_STD         16'h05EE
`define RCW_LEN_VLAN        16'h05F2
`define RCW_TPID_CTAG       16'h8100
`define RCW_TPID_STAG       16'h88A8
`define RCW_TAGS_STACKED    4'h8
`define RCW_TAGS_SINGLE     4'h1
`define RCW_TAGS_NONE       4'h0

`endif

// file: rtl/rcw_pkg.sv
// Types shared by the receiver configuration word and its policy logic.
// Assumes rcw_consts.svh is on the include path.
package rcw_pkg;

  // ----------------------------------------------------------------
  // Stored configuration fields
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        jumbo;
    logic        fcsPass;
    logic        rxEnable;
    logic        vlanEn;
    logic        keepPreamble;
    logic        ltCheckOff;
    logic        ctrlLenOff;
    logic        enhVlan;
    logic        stackVlan;
    logic [15:0] pauseAddrHigh;
  } rcw_cfg_type;

  // ----------------------------------------------------------------
  // Controls handed to the receive datapath
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        jumboOk;
    logic        fcsForward;
    logic        fcsCheck;
    logic        rxIgnore;
    logic        keepPreamble;
    logic        ltCheckEn;
    logic        ctrlLenCheckEn;
    logic        countTagged;
    logic        tagHit;
    logic [3:0]  maxTags;
    logic [3:0]  ltTagSkip;
    logic [15:0] maxFrameLen;
    logic        pauseDestHit;
  } rcw_policy_type;

endpackage : rcw_pkg

// file: rtl/rcw_frame_policy.sv
// Combinational derivation of receive datapath controls from the
// applied configuration and the current frame header fields.
// Assumes all inputs come from logic on the same clock.
`timescale 1ns/1ps
`include "rcw_consts.svh"

module rcw_frame_policy
  import rcw_pkg::*;
(
  input  rcw_cfg_type    cfg,
  input  logic [15:0]    etherType,
  input  logic           frameTagged,
  input  logic [3:0]     tagCount,
  input  logic [7:0]     destByte4,
  input  logic [7:0]     destByte5,
  output rcw_policy_type policy
);

  // ----------------------------------------------------------------
  // Policy decode
  // ----------------------------------------------------------------
  always_comb
  begin
    policy                = '0;
    policy.jumboOk        = cfg.jumbo;                                   // see RULE_03
    policy.fcsForward     = cfg.fcsPass;                                 // see RULE_04
    policy.fcsCheck       = 1'b1;                                        // see RULE_05
    policy.rxIgnore       = ~cfg.rxEnable;                               // see RULE_06
    policy.keepPreamble   = cfg.keepPreamble;                            // see RULE_09
    policy.ltCheckEn      = ~cfg.ltCheckOff;                             // see RULE_10
    policy.ctrlLenCheckEn = ~cfg.ctrlLenOff;                             // see RULE_11
    policy.countTagged    = cfg.vlanEn;                                  // see RULE_08
    policy.tagHit         = (etherType == `RCW_TPID_CTAG) ||
                            (cfg.stackVlan && (etherType == `RCW_TPID_STAG)); // see RULE_15
    policy.maxTags        = cfg.stackVlan ? `RCW_TAGS_STACKED : `RCW_TAGS_SINGLE; // see RULE_14
    if (!cfg.enhVlan)
    begin
      policy.ltTagSkip = `RCW_TAGS_NONE;
    end
    else if (cfg.stackVlan)
    begin
      policy.ltTagSkip = (tagCount > `RCW_TAGS_STACKED) ? `RCW_TAGS_STACKED : tagCount; // see RULE_13
    end
    else
    begin
      policy.ltTagSkip = (tagCount != `RCW_TAGS_NONE) ? `RCW_TAGS_SINGLE : `RCW_TAGS_NONE; // see RULE_12
    end
    policy.maxFrameLen    = (cfg.vlanEn && frameTagged) ? `RCW_LEN_VLAN : `RCW_LEN_STD; // see RULE_07
    policy.pauseDestHit   = ({destByte5, destByte4} == cfg.pauseAddrHigh); // see RULE_17
  end

endmodule : rcw_frame_policy

// file: rtl/rcw_rx_config_word_one.sv
// Second receiver configuration word: soft reset, receive enables and
// the upper pause-frame address, with gap-aligned application.
// Assumes a single-cycle management access port and a gap flag from
// the receiver, both on clk_sys.
//
// Summary of operation
// RULE_01: Top bit write resets receiver, self-clears.
// RULE_02: Soft reset restores receiver configuration defaults.
// RULE_03: Jumbo bit permits frames beyond legal maximum.
// RULE_04: FCS pass bit forwards or strips FCS.
// RULE_05: FCS always checked regardless of setting.
// RULE_06: Receive enable resets high; low ignores input.
// RULE_07: VLAN enable raises tagged maximum to 1522.
// RULE_08: VLAN disabled means tagged frames not counted.
// RULE_09: Preamble bit keeps or discards received preamble.
// RULE_10: Length/type check disable skips those checks.
// RULE_11: Control length disable stops oversize control marking.
// RULE_12: Enhanced VLAN checks length/type after tag.
// RULE_13: Enhanced plus stacked checks after last tag.
// RULE_14: Stacked mode handles up to eight tags.
// RULE_15: Stacked mode also recognises tag 0x88A8.
// RULE_16: Low half stores pause address upper bits.
// RULE_17: Pause address matched and used as source.
// RULE_18: First address byte sits in lowest byte.
// RULE_19: Settings apply in gaps; soft reset immediate.
// RULE_20: Reserved bits read zero, writes ignored.
`timescale 1ns/1ps
`include "rcw_consts.svh"

module rcw_rx_config_word_one
  import rcw_pkg::*;
(
  input  logic                   clk_sys,
  input  logic                   resetn,
  input  logic [`RCW_ADDR_W-1:0] mgmtAddr,
  input  logic                   mgmtWrEn,
  input  logic                   mgmtRdEn,
  input  logic [31:0]            mgmtWrData,
  output logic [31:0]            mgmtRdData,
  output logic                   mgmtRdValid,
  input  logic                   rxGap,
  input  logic [15:0]            etherType,
  input  logic                   frameTagged,
  input  logic [3:0]             tagCount,
  input  logic [7:0]             destByte4,
  input  logic [7:0]             destByte5,
  output logic                   rxSoftReset,
  output rcw_policy_type         rxPolicy,
  output logic [7:0]             pauseSrcByte4,
  output logic [7:0]             pauseSrcByte5
);

  // ----------------------------------------------------------------
  // Word packing
  // ----------------------------------------------------------------
  function automatic rcw_cfg_type unpackWord(input logic [31:0] w);
    rcw_cfg_type c;
    c               = '0;
    c.jumbo         = w[`RCW_BIT_JUMBO];
    c.fcsPass       = w[`RCW_BIT_FCS_PASS];
    c.rxEnable      = w[`RCW_BIT_RX_ENABLE];
    c.vlanEn        = w[`RCW_BIT_VLAN];
    c.keepPreamble  = w[`RCW_BIT_PREAMBLE];
    c.ltCheckOff    = w[`RCW_BIT_LT_OFF];
    c.ctrlLenOff    = w[`RCW_BIT_CTRL_OFF];
    c.enhVlan       = w[`RCW_BIT_ENH_VLAN];
    c.stackVlan     = w[`RCW_BIT_STACK_VLAN];
    c.pauseAddrHigh = w[`RCW_PAUSE_MSB:`RCW_PAUSE_LSB];              // see RULE_16
    return c;
  endfunction : unpackWord

  function automatic logic [31:0] packWord(input rcw_cfg_type c, input logic rst);
    logic [31:0] w;
    w                               = '0;
    w[`RCW_BIT_RESET]               = rst;
    w[`RCW_BIT_JUMBO]               = c.jumbo;
    w[`RCW_BIT_FCS_PASS]            = c.fcsPass;
    w[`RCW_BIT_RX_ENABLE]           = c.rxEnable;
    w[`RCW_BIT_VLAN]                = c.vlanEn;
    w[`RCW_BIT_PREAMBLE]            = c.keepPreamble;
    w[`RCW_BIT_LT_OFF]              = c.ltCheckOff;
    w[`RCW_BIT_CTRL_OFF]            = c.ctrlLenOff;
    w[`RCW_BIT_ENH_VLAN]            = c.enhVlan;
    w[`RCW_BIT_STACK_VLAN]          = c.stackVlan;
    w[`RCW_PAUSE_MSB:`RCW_PAUSE_LSB] = c.pauseAddrHigh;
    return w;
  endfunction : packWord

  localparam rcw_cfg_type CFG_DEFAULT = unpackWord(`RCW_WORD1_RESET);

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  rcw_cfg_type    stagedCfg_reg;
  rcw_cfg_type    activeCfg_reg;
  logic           softRst_reg;
  logic [31:0]    rdData_reg;
  logic           rdValid_reg;
  rcw_policy_type policy_reg;
  rcw_policy_type policyNext;
  logic [7:0]     srcByte4_reg;
  logic [7:0]     srcByte5_reg;
  logic           wrHit;
  logic           rdHit;
  logic           srstWrite;

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  assign wrHit     = mgmtWrEn && (mgmtAddr == `RCW_ADDR_WORD1);
  assign rdHit     = mgmtRdEn && (mgmtAddr == `RCW_ADDR_WORD1);
  assign srstWrite = wrHit && mgmtWrData[`RCW_BIT_RESET];

  // ----------------------------------------------------------------
  // Self-clearing receiver reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      softRst_reg <= 1'b0;
    end
    else
    begin
      softRst_reg <= srstWrite;                                        // see RULE_01
    end
  end

  // ----------------------------------------------------------------
  // Software-visible staged settings
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      stagedCfg_reg <= CFG_DEFAULT;
    end
    else if (srstWrite)
    begin
      stagedCfg_reg <= CFG_DEFAULT;                                    // see RULE_02
    end
    else if (wrHit)
    begin
      stagedCfg_reg <= unpackWord(mgmtWrData & `RCW_WORD1_RMASK);      // see RULE_20
    end
  end

  // ----------------------------------------------------------------
  // Settings applied to the receiver
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      activeCfg_reg <= CFG_DEFAULT;                                    // see RULE_06
    end
    else if (srstWrite)
    begin
      activeCfg_reg <= CFG_DEFAULT;                                    // see RULE_19
    end
    else if (rxGap)
    begin
      activeCfg_reg <= stagedCfg_reg;                                  // see RULE_19
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rdData_reg  <= 32'h0000_0000;
      rdValid_reg <= 1'b0;
    end
    else
    begin
      rdValid_reg <= mgmtRdEn;
      if (rdHit)
      begin
        rdData_reg <= packWord(stagedCfg_reg, softRst_reg);            // see RULE_20
      end
      else
      begin
        rdData_reg <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Datapath controls
  // ----------------------------------------------------------------
  rcw_frame_policy i_rcw_frame_policy (
    .cfg         (activeCfg_reg),
    .etherType   (etherType),
    .frameTagged (frameTagged),
    .tagCount    (tagCount),
    .destByte4   (destByte4),
    .destByte5   (destByte5),
    .policy      (policyNext)
  );

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      policy_reg <= '0;
    end
    else
    begin
      policy_reg <= policyNext;                                        // see RULE_03
    end
  end

  // ----------------------------------------------------------------
  // Pause source address bytes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      srcByte4_reg <= 8'h00;
      srcByte5_reg <= 8'h00;
    end
    else
    begin
      srcByte4_reg <= activeCfg_reg.pauseAddrHigh[7:0];                // see RULE_18
      srcByte5_reg <= activeCfg_reg.pauseAddrHigh[15:8];               // see RULE_17
    end
  end

  assign mgmtRdData    = rdData_reg;
  assign mgmtRdValid   = rdValid_reg;
  assign rxSoftReset   = softRst_reg;
  assign rxPolicy      = policy_reg;
  assign pauseSrcByte4 = srcByte4_reg;
  assign pauseSrcByte5 = srcByte5_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_srst_pulse;
    @(posedge clk_sys) disable iff (!resetn)
      srstWrite ##1 !srstWrite |=> !softRst_reg;
  endproperty
  a_srst_pulse: assert property (p_srst_pulse) // see RULE_01
    else $error("soft reset did not self-clear");

  property p_srst_set;
    @(posedge clk_sys) disable iff (!resetn)
      srstWrite |=> softRst_reg;
  endproperty
  a_srst_set: assert property (p_srst_set) // see RULE_01
    else $error("soft reset not raised by write");

  property p_srst_defaults;
    @(posedge clk_sys) disable iff (!resetn)
      softRst_reg |-> (stagedCfg_reg == CFG_DEFAULT) && (activeCfg_reg == CFG_DEFAULT);
  endproperty
  a_srst_defaults: assert property (p_srst_defaults) // see RULE_02
    else $error("soft reset left non-default settings");

  property p_jumbo;
    @(posedge clk_sys) disable iff (!resetn)
      ##1 (rxPolicy.jumboOk == $past(activeCfg_reg.jumbo));
  endproperty
  a_jumbo: assert property (p_jumbo) // see RULE_03
    else $error("jumbo control mismatch");

  property p_fcs_check;
    @(posedge clk_sys) disable iff (!resetn)
      $past(resetn) |-> rxPolicy.fcsCheck && (rxPolicy.fcsForward == $past(activeCfg_reg.fcsPass));
  endproperty
  a_fcs_check: assert property (p_fcs_check) // see RULE_05
    else $error("FCS check or forward wrong");

  property p_rx_ignore;
    @(posedge clk_sys) disable iff (!resetn)
      $past(resetn) |-> (rxPolicy.rxIgnore == !$past(activeCfg_reg.rxEnable));
  endproperty
  a_rx_ignore: assert property (p_rx_ignore) // see RULE_06
    else $error("receive ignore not inverse of enable");

  property p_vlan_len;
    @(posedge clk_sys) disable iff (!resetn)
      (activeCfg_reg.vlanEn && frameTagged) |=> (rxPolicy.maxFrameLen == `RCW_LEN_VLAN);
  endproperty
  a_vlan_len: assert property (p_vlan_len) // see RULE_07
    else $error("tagged maximum not 1522");

  property p_std_len;
    @(posedge clk_sys) disable iff (!resetn)
      !(activeCfg_reg.vlanEn && frameTagged) |=> (rxPolicy.maxFrameLen == `RCW_LEN_STD);
  endproperty
  a_std_len: assert property (p_std_len) // see RULE_07
    else $error("standard maximum not 1518");

  property p_stag;
    @(posedge clk_sys) disable iff (!resetn)
      (etherType == `RCW_TPID_STAG) |=> (rxPolicy.tagHit == $past(activeCfg_reg.stackVlan));
  endproperty
  a_stag: assert property (p_stag) // see RULE_15
    else $error("service tag recognition wrong");

  property p_gap_hold;
    @(posedge clk_sys) disable iff (!resetn)
      (!rxGap && !srstWrite) |=> $stable(activeCfg_reg);
  endproperty
  a_gap_hold: assert property (p_gap_hold) // see RULE_19
    else $error("settings changed outside a gap");

  property p_write_apply;
    @(posedge clk_sys) disable iff (!resetn)
      (wrHit && !srstWrite) ##1 (rxGap && !srstWrite) |=> (activeCfg_reg == $past(stagedCfg_reg));
  endproperty
  a_write_apply: assert property (p_write_apply) // see RULE_19
    else $error("staged setting not applied in gap");

  property p_reserved;
    @(posedge clk_sys) disable iff (!resetn)
      mgmtRdValid |-> ((mgmtRdData & ~(`RCW_WORD1_RMASK | 32'h8000_0000)) == 32'h0000_0000);
  endproperty
  a_reserved: assert property (p_reserved) // see RULE_20
    else $error("reserved bits read non-zero");

  property p_pause_store;
    @(posedge clk_sys) disable iff (!resetn)
      (wrHit && !srstWrite) |=> (stagedCfg_reg.pauseAddrHigh == $past(mgmtWrData[15:0]));
  endproperty
  a_pause_store: assert property (p_pause_store) // see RULE_16
    else $error("pause address not stored");

endmodule : rcw_rx_config_word_one

// file: tb/test_rcw_rx_config_word_one.sv
// Self-checking bench for the second receiver configuration word.
// Assumes rcw_consts.svh on the include path and rcw_pkg compiled first.
`timescale 1ns/1ps
`include "rcw_consts.svh"

module test_rcw_rx_config_word_one
  import rcw_pkg::*;
;
  logic                   clk_sys;
  logic                   resetn;
  logic [`RCW_ADDR_W-1:0] mgmtAddr;
  logic                   mgmtWrEn;
  logic                   mgmtRdEn;
  logic [31:0]            mgmtWrData;
  logic [31:0]            mgmtRdData;
  logic                   mgmtRdValid;
  logic                   rxGap;
  logic [15:0]            etherType;
  logic                   frameTagged;
  logic [3:0]             tagCount;
  logic [7:0]             destByte4;
  logic [7:0]             destByte5;
  logic                   rxSoftReset;
  rcw_policy_type         rxPolicy;
  logic [7:0]             pauseSrcByte4;
  logic [7:0]             pauseSrcByte5;
  int                     n_errors;
  int                     n_tests;
  logic [31:0]            cfgTab [7];
  logic [15:0]            hEt    [4];
  logic                   hTg    [4];
  logic [3:0]             hTc    [4];
  logic [15:0]            hDest  [4];
  logic [31:0]            applied;

  rcw_rx_config_word_one i_rcw_rx_config_word_one (
    .clk_sys       (clk_sys),
    .resetn        (resetn),
    .mgmtAddr      (mgmtAddr),
    .mgmtWrEn      (mgmtWrEn),
    .mgmtRdEn      (mgmtRdEn),
    .mgmtWrData    (mgmtWrData),
    .mgmtRdData    (mgmtRdData),
    .mgmtRdValid   (mgmtRdValid),
    .rxGap         (rxGap),
    .etherType     (etherType),
    .frameTagged   (frameTagged),
    .tagCount      (tagCount),
    .destByte4     (destByte4),
    .destByte5     (destByte5),
    .rxSoftReset   (rxSoftReset),
    .rxPolicy      (rxPolicy),
    .pauseSrcByte4 (pauseSrcByte4),
    .pauseSrcByte5 (pauseSrcByte5)
  );

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  initial
  begin
    #100_000;
    n_errors++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    if (n_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic ticks(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : ticks

  // Called at a falling edge; hold keeps the strobe up for a back-to-back write
  task automatic wrWord(input logic [15:0] a, input logic [31:0] d, input bit hold);
    mgmtAddr   = a;
    mgmtWrData = d;
    mgmtWrEn   = 1'b1;
    @(negedge clk_sys);
    if (!hold)
      mgmtWrEn = 1'b0;
  endtask : wrWord

  task automatic rdWord(input logic [15:0] a, input logic [31:0] exp, input string what);
    mgmtAddr = a;
    mgmtRdEn = 1'b1;
    @(negedge clk_sys);
    mgmtRdEn = 1'b0;
    chk({what, " valid"}, mgmtRdValid, 1'b1);
    chk(what, mgmtRdData, exp);
    @(negedge clk_sys);
    chk({what, " valid off"}, mgmtRdValid, 1'b0);
    chk({what, " data off"}, mgmtRdData, 32'h0000_0000);
  endtask : rdWord

  function automatic rcw_policy_type expPol(input logic [31:0] w);
    rcw_policy_type p;
    p.jumboOk        = w[30];
    p.fcsForward     = w[29];
    p.fcsCheck       = 1'b1;
    p.rxIgnore       = ~w[28];
    p.keepPreamble   = w[26];
    p.ltCheckEn      = ~w[25];
    p.ctrlLenCheckEn = ~w[24];
    p.countTagged    = w[27];
    p.tagHit         = (etherType == `RCW_TPID_CTAG) || (w[21] && etherType == `RCW_TPID_STAG);
    p.maxTags        = w[21] ? `RCW_TAGS_STACKED : `RCW_TAGS_SINGLE;
    p.ltTagSkip      = !w[23] ? 4'h0 : w[21] ? ((tagCount > 4'h8) ? 4'h8 : tagCount) : {3'h0, tagCount != 4'h0};
    p.maxFrameLen    = (w[27] && frameTagged) ? `RCW_LEN_VLAN : `RCW_LEN_STD;
    p.pauseDestHit   = ({destByte5, destByte4} == w[15:0]);
    return p;
  endfunction : expPol

  task automatic setHdr(input int k);
    etherType   = hEt[k];
    frameTagged = hTg[k];
    tagCount    = hTc[k];
    {destByte5, destByte4} = hDest[k];
    ticks(2);
  endtask : setHdr

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    n_errors = 0;
    n_tests  = 0;
    cfgTab   = '{32'h1000_0000, 32'h7FFF_FFFF, 32'h0000_0000, 32'h6800_1234,
                 32'h1A80_BBAA, 32'h15A0_AABB, 32'h1020_0000};
    hEt      = '{16'h8100, 16'h88A8, 16'h0800, 16'h88A8};
    hTg      = '{1'b1, 1'b1, 1'b0, 1'b1};
    hTc      = '{4'h1, 4'h9, 4'h0, 4'h3};
    hDest    = '{16'h0000, 16'hBBAA, 16'h1234, 16'hAABB};
    resetn = 1'b0;
    mgmtAddr = '0;
    mgmtWrEn = 1'b0;
    mgmtRdEn = 1'b0;
    mgmtWrData = '0;
    rxGap = 1'b0;
    etherType = '0;
    frameTagged = 1'b0;
    tagCount = '0;
    destByte4 = '0;
    destByte5 = '0;
    repeat (8) @(negedge clk_sys);
    resetn = 1'b1;
    ticks(1);
    rdWord(16'h0404, `RCW_WORD1_RESET, "reset word");
    applied = `RCW_WORD1_RESET;
    foreach (cfgTab[i])
    begin
      setHdr(i % 4);
      wrWord(16'h0404, cfgTab[i], 0);
      ticks(1);
      rdWord(16'h0404, cfgTab[i] & `RCW_WORD1_RMASK, "readback");
      chk("policy held", rxPolicy, expPol(applied));
      rxGap = 1'b1;
      ticks(3);
      rxGap = 1'b0;
      applied = cfgTab[i];
      chk("pause src", {pauseSrcByte5, pauseSrcByte4}, applied[15:0]);
      for (int k = 0; k < 4; k++)
      begin
        setHdr(k);
        chk("policy", rxPolicy, expPol(applied));
      end
    end
    wrWord(16'h0404, 32'hFFFF_FFFF, 0);
    chk("soft reset pulse", rxSoftReset, 1'b1);
    ticks(1);
    chk("soft reset clear", rxSoftReset, 1'b0);
    chk("soft reset policy", rxPolicy, expPol(`RCW_WORD1_RESET));
    rdWord(16'h0404, `RCW_WORD1_RESET, "after soft reset");
    wrWord(16'h0400, 32'h7FFF_FFFF, 0);
    ticks(1);
    rdWord(16'h0404, `RCW_WORD1_RESET, "unmapped write");
    rdWord(16'h0408, 32'h0000_0000, "unmapped read");
    wrWord(16'h0404, 32'h6800_1234, 1);
    wrWord(16'h0404, 32'h4000_00FF, 0);
    rxGap = 1'b1;
    ticks(1);
    rdWord(16'h0404, 32'h4000_00FF, "back to back");
    chk("gap pause", {pauseSrcByte5, pauseSrcByte4}, 16'h00FF);
    ticks(3);
    resetn = 1'b0;
    ticks(1);
    chk("policy in reset", rxPolicy, '0);
    chk("pause in reset", {pauseSrcByte5, pauseSrcByte4}, 16'h0000);
    resetn = 1'b1;
    ticks(1);
    chk("policy after reset", rxPolicy, expPol(`RCW_WORD1_RESET));
    rdWord(16'h0404, `RCW_WORD1_RESET, "second reset");
    test_done();
  end

endmodule : test_rcw_rx_config_word_one
